// [src/ds_forward_buffer.v]
// Downstream forwarding buffer of one RF channel: store-and-forward packet
// queues, strict-priority scheduling, null packet rate adaptation and PCR
// restamping, with a latency monitor on the data path.
// Assumes the tunnel source delivers one byte per cycle with a last marker
// and cannot be stalled; the RF side may stall through rf_ready.
// Function
// RULE1: Isolated data packets leave within 200 us plus interleaver delay.
// RULE2: Streaming mode latency runs from packet end to frame's first byte out.
// RULE3: Tunnel modes latency runs from packet end to first MPEG byte out.
// RULE4: Forwarding of a packet starts only after it is wholly received.
// RULE5: Isolated means each packet finishes sending before the next arrives.
// RULE6: The latency bound applies to data packets, not video traffic.
// RULE7: Keep skew between bonded channels below 500 us.
// RULE8: Data channel buffer holds at least 8 ms of traffic.
// RULE9: Video channel buffer holds at least 10 ms of traffic.
// RULE10: Headend sends video as constant-rate stream with null padding.
// RULE11: Headend stream rate matches the configured channel rate exactly.
// RULE12: Transport tunnel mode is mandatory; multichannel MPEG mode optional.
// RULE13: Synchronous mode is mandatory; asynchronous mode is optional.
// RULE14: In asynchronous mode insert or delete null packets for rate fit.
// RULE15: Outgoing PCR values stay compliant, restamped from a local clock.
// RULE16: Headend respects the advertised count of asynchronous channels.
// RULE17: Two queues, expedited above best effort, strict priority.
// RULE18: A packet arriving to a full buffer is dropped and counted.
`timescale 1ns/1ps
`include "ds_forward_defs.vh"
module ds_forward_buffer #(
	parameter QUEUE_AW = `QUEUE_AW,
	parameter LATENCY_CYCLES = `LATENCY_CYCLES,
	parameter SKEW_CYCLES = `SKEW_CYCLES,
	parameter NULL_GAP_CYCLES = `NULL_GAP_CYCLES
) (
	input wire clock,
	input wire reset,
	input wire [1:0] mode,
	input wire async_mode,
	input wire in_valid,
	input wire [7:0] in_data,
	input wire in_last,
	input wire in_class_ef,
	input wire in_is_video,
	output wire rf_valid,
	output wire [7:0] rf_data,
	output wire rf_start,
	output wire rf_last,
	input wire rf_ready,
	output reg [15:0] drop_count,
	output reg [15:0] deleted_count,
	output reg [15:0] inserted_count,
	output reg [15:0] latency_max,
	output reg latency_violation,
	output reg skew_violation
);
	localparam DEPTH = 1 << QUEUE_AW;
	localparam O_IDLE = 2'h0;
	localparam O_DATA = 2'h1;
	localparam O_NULL = 2'h2;

	// Word layout: {last, video, data}; queue 1 is expedited, queue 0 best effort.
	reg [9:0] mem [0:2*DEPTH-1];
	reg [QUEUE_AW:0] wr_ptr [0:1];
	reg [QUEUE_AW:0] commit_ptr [0:1];
	reg [QUEUE_AW:0] rd_ptr [0:1];
	reg [QUEUE_AW:0] pkt_cnt [0:1];
	reg [31:0] commit_time [0:1];
	reg [1:0] arm_tog;
	reg [1:0] seen_tog;
	reg wq;
	reg [7:0] in_pos;
	reg dropping;
	reg null_hi;
	reg [31:0] now;
	reg [1:0] state;
	reg oq;
	reg [7:0] opos;
	reg adapt_seen;
	reg pcr_sel;
	reg [47:0] pcr_snap;
	reg null_due;
	reg [15:0] gap_cnt;
	reg [5:0] pcr_phase;
	reg [8:0] pcr_ext;
	reg [32:0] pcr_base;
	reg [15:0] next_latency;
	reg [9:0] push_word;
	reg [7:0] out_byte;
	wire q_sel;
	wire tunnel_mode;
	wire adapt_active;
	wire [QUEUE_AW:0] q_used;
	wire in_full;
	wire push_valid;
	wire push_ready;
	wire push_go;
	wire [9:0] rd_word;
	wire take;
	wire take_q;
	wire [31:0] lat_now;

	function [QUEUE_AW:0] used_words;
		input [QUEUE_AW:0] wp;
		input [QUEUE_AW:0] rp;
		begin
			used_words = wp - rp;
		end
	endfunction

	function [QUEUE_AW:0] ptr_inc;
		input [QUEUE_AW:0] p;
		begin
			ptr_inc = p + 1'b1;
		end
	endfunction

	// RULE12: both tunnel types
	assign tunnel_mode = (mode != `MODE_PACKET_STREAMING);
	// Rate adaptation only applies to transport streams in asynchronous mode.
	// RULE13: synchronous passes through
	assign adapt_active = async_mode && tunnel_mode;
	assign q_sel = (in_pos == 8'h00) ? in_class_ef : wq;
	assign q_used = used_words(wr_ptr[q_sel], rd_ptr[q_sel]);
	// RULE8: full detection per queue
	// RULE9: video shares queues
	assign in_full = (q_used == DEPTH[QUEUE_AW:0]);
	assign rd_word = mem[{oq, rd_ptr[oq][QUEUE_AW-1:0]}];
	assign take = (state == O_IDLE) &&
		((pkt_cnt[1] != {(QUEUE_AW+1){1'b0}}) || (pkt_cnt[0] != {(QUEUE_AW+1){1'b0}}));
	// RULE17: expedited queue first
	assign take_q = (pkt_cnt[1] != {(QUEUE_AW+1){1'b0}});
	assign lat_now = now - commit_time[oq];

	// Input side: stores whole packets and publishes them only at their end.
	always @(posedge clock)
	begin
		if (reset)
		begin
			wr_ptr[0] <= {(QUEUE_AW+1){1'b0}};
			wr_ptr[1] <= {(QUEUE_AW+1){1'b0}};
			commit_ptr[0] <= {(QUEUE_AW+1){1'b0}};
			commit_ptr[1] <= {(QUEUE_AW+1){1'b0}};
			pkt_cnt[0] <= {(QUEUE_AW+1){1'b0}};
			pkt_cnt[1] <= {(QUEUE_AW+1){1'b0}};
			commit_time[0] <= 32'h00000000;
			commit_time[1] <= 32'h00000000;
			arm_tog <= 2'h0;
			wq <= 1'b0;
			in_pos <= 8'h00;
			dropping <= 1'b0;
			null_hi <= 1'b0;
			drop_count <= 16'h0000;
			deleted_count <= 16'h0000;
			now <= 32'h00000000;
		end
		else
		begin
			now <= now + 1'b1;
			if (take)
				pkt_cnt[take_q] <= pkt_cnt[take_q] - 1'b1;
			if (in_valid)
			begin
				wq <= q_sel;
				if (in_pos != 8'hFF)
					in_pos <= in_pos + 1'b1;
				if (!dropping && !in_full)
				begin
					mem[{q_sel, wr_ptr[q_sel][QUEUE_AW-1:0]}] <= {in_last, in_is_video, in_data};
					wr_ptr[q_sel] <= ptr_inc(wr_ptr[q_sel]);
				end
				if (in_pos == `TS_POS_PID_HI)
					null_hi <= (in_data[4:0] == `NULL_PID_HI);
				// The low PID byte must match too, so only a true null PID qualifies.
				if (in_pos == `TS_POS_PID_LO)
					null_hi <= null_hi && (in_data == `NULL_PID_LO);
				if (in_last)
				begin
					in_pos <= 8'h00;
					dropping <= 1'b0;
					null_hi <= 1'b0;
					if (dropping || in_full)
					begin
						// RULE18: discard and count
						wr_ptr[q_sel] <= commit_ptr[q_sel];
						drop_count <= drop_count + 1'b1;
					end
					else if (adapt_active && null_hi && (in_pos == `TS_LEN - 1'b1))
					begin
						// RULE14: null deletion
						wr_ptr[q_sel] <= commit_ptr[q_sel];
						deleted_count <= deleted_count + 1'b1;
					end
					else
					begin
						// RULE4: publish complete packet
						commit_ptr[q_sel] <= ptr_inc(wr_ptr[q_sel]);
						pkt_cnt[q_sel] <= pkt_cnt[q_sel] + 1'b1 -
							((take && take_q == q_sel) ? 1'b1 : 1'b0);
						// RULE5: arm monitor only when this queue holds no published packet and is not being sent
						if (pkt_cnt[q_sel] == {(QUEUE_AW+1){1'b0}} && !(state != O_IDLE && oq == q_sel))
						begin
							commit_time[q_sel] <= now;
							arm_tog[q_sel] <= ~seen_tog[q_sel];
						end
					end
				end
				else if (in_full)
					dropping <= 1'b1;
			end
		end
	end

	// Local transport clock: 27 MHz derived from 40 MHz by a phase accumulator.
	always @(posedge clock)
	begin
		if (reset)
		begin
			pcr_phase <= 6'h00;
			pcr_ext <= 9'h000;
			pcr_base <= 33'h000000000;
			gap_cnt <= 16'h0000;
			null_due <= 1'b0;
		end
		else
		begin
			// One extra bit keeps the sum from wrapping before the compare.
			if ({1'b0, pcr_phase} + {1'b0, `PCR_RATE_NUM} >= {1'b0, `PCR_RATE_DEN})
			begin
				pcr_phase <= pcr_phase + `PCR_RATE_NUM - `PCR_RATE_DEN;
				if (pcr_ext == `PCR_EXT_MAX)
				begin
					pcr_ext <= 9'h000;
					pcr_base <= pcr_base + 1'b1;
				end
				else
					pcr_ext <= pcr_ext + 1'b1;
			end
			else
				pcr_phase <= pcr_phase + `PCR_RATE_NUM;
			// A pending null slot is set by the divider; the set wins over the insert's clear.
			if (gap_cnt == NULL_GAP_CYCLES[15:0] - 1'b1)
			begin
				gap_cnt <= 16'h0000;
				null_due <= 1'b1;
			end
			else
			begin
				gap_cnt <= gap_cnt + 1'b1;
				if (state == O_IDLE && !take && adapt_active)
					null_due <= 1'b0;
			end
		end
	end

	always @*
	begin
		out_byte = rd_word[7:0];
		// RULE15: restamp outgoing PCR
		if (pcr_sel && opos >= `TS_POS_PCR_FIRST && opos <= `TS_POS_PCR_LAST)
			out_byte = pcr_snap[47 - 8 * (opos - `TS_POS_PCR_FIRST) -: 8];
		push_word = {opos == 8'h00, rd_word[9], out_byte};
		if (state == O_NULL)
		begin
			case (opos)
				8'h00: push_word = {2'h2, `TS_SYNC};
				`TS_POS_PID_HI: push_word = {2'h0, `NULL_PID_HI};
				`TS_POS_PID_LO: push_word = {2'h0, `NULL_PID_LO};
				`TS_POS_ADAPT_CTRL: push_word = {2'h0, `NULL_ADAPT};
				default: push_word = {1'b0, opos == `TS_LEN - 1'b1, `NULL_FILL};
			endcase
		end
	end

	assign push_valid = (state == O_DATA) || (state == O_NULL);
	assign push_go = push_valid && push_ready;

	always @*
	begin
		next_latency = latency_max;
		if (lat_now[31:16] == 16'h0000 && lat_now[15:0] > latency_max)
			next_latency = lat_now[15:0];
		else if (lat_now[31:16] != 16'h0000)
			next_latency = 16'hFFFF;
	end

	// Output side: strict priority scheduler feeding the RF FIFO.
	always @(posedge clock)
	begin
		if (reset)
		begin
			state <= O_IDLE;
			oq <= 1'b0;
			opos <= 8'h00;
			rd_ptr[0] <= {(QUEUE_AW+1){1'b0}};
			rd_ptr[1] <= {(QUEUE_AW+1){1'b0}};
			seen_tog <= 2'h0;
			adapt_seen <= 1'b0;
			pcr_sel <= 1'b0;
			pcr_snap <= 48'h000000000000;
			inserted_count <= 16'h0000;
			latency_max <= 16'h0000;
			latency_violation <= 1'b0;
			skew_violation <= 1'b0;
		end
		else
		begin
			case (state)
				O_IDLE:
				begin
					opos <= 8'h00;
					adapt_seen <= 1'b0;
					pcr_sel <= 1'b0;
					if (take)
					begin
						// RULE17: strict priority pick
						oq <= take_q;
						state <= O_DATA;
					end
					else if (adapt_active && null_due)
					begin
						// RULE14: null insertion
						state <= O_NULL;
						inserted_count <= inserted_count + 1'b1;
					end
				end
				O_DATA:
				if (push_go)
				begin
					rd_ptr[oq] <= ptr_inc(rd_ptr[oq]);
					if (opos != 8'hFF)
						opos <= opos + 1'b1;
					// RULE2: measure at first byte out
					// RULE3: same point for tunnel modes
					// RULE6: data packets only
					if (opos == 8'h00 && arm_tog[oq] != seen_tog[oq] && !rd_word[8])
					begin
						seen_tog[oq] <= arm_tog[oq];
						latency_max <= next_latency;
						// RULE1: latency bound check
						if (lat_now >= LATENCY_CYCLES)
							latency_violation <= 1'b1;
						// RULE7: skew contribution check
						if (lat_now >= SKEW_CYCLES)
							skew_violation <= 1'b1;
					end
					else if (opos == 8'h00 && arm_tog[oq] != seen_tog[oq])
						seen_tog[oq] <= arm_tog[oq];
					if (opos == `TS_POS_ADAPT_CTRL)
						adapt_seen <= rd_word[`ADAPT_PRESENT_BIT];
					if (opos == `TS_POS_ADAPT_LEN && rd_word[7:0] == 8'h00)
						adapt_seen <= 1'b0;
					if (opos == `TS_POS_ADAPT_FLAGS)
					begin
						pcr_sel <= adapt_active && adapt_seen && rd_word[`PCR_FLAG_BIT];
						pcr_snap <= {pcr_base, 6'h3F, pcr_ext};
					end
					if (rd_word[9])
						state <= O_IDLE;
				end
				O_NULL:
				if (push_go)
				begin
					opos <= opos + 1'b1;
					if (opos == `TS_LEN - 1'b1)
						state <= O_IDLE;
				end
				default:
					state <= O_IDLE;
			endcase
		end
	end

	out_fifo #(
		.WIDTH(10),
		.DEPTH(`OUT_FIFO_DEPTH),
		.AW(3)
	) u_out_fifo (
		.clock(clock),
		.reset(reset),
		.in_valid(push_valid),
		.in_data(push_word),
		.in_ready(push_ready),
		.out_valid(rf_valid),
		.out_data({rf_start, rf_last, rf_data}),
		.out_ready(rf_ready)
	);
endmodule // ds_forward_buffer

// [src/ds_forward_defs.vh]
// Constants for the downstream forwarding buffer: offsets, codes and timing.
// Assumes a 40 MHz system clock and byte-wide transport packet framing.
`ifndef DS_FORWARD_DEFS_VH
`define DS_FORWARD_DEFS_VH

`define CLOCK_MHZ 40
`define LATENCY_US 200
`define LATENCY_CYCLES (`LATENCY_US * `CLOCK_MHZ)
`define SKEW_US 500
`define SKEW_CYCLES (`SKEW_US * `CLOCK_MHZ)
`define QUEUE_AW 14
`define OUT_FIFO_DEPTH 8
`define NULL_GAP_CYCLES 1600

`define MODE_PACKET_STREAMING 2'h0
`define MODE_TRANSPORT_TUNNEL 2'h1
`define MODE_MULTICHANNEL_MPEG 2'h2

`define TS_LEN 8'hBC
`define TS_SYNC 8'h47
`define NULL_PID_HI 8'h1F
`define NULL_PID_LO 8'hFF
`define NULL_ADAPT 8'h10
`define NULL_FILL 8'hFF
`define TS_POS_PID_HI 8'h01
`define TS_POS_PID_LO 8'h02
`define TS_POS_ADAPT_CTRL 8'h03
`define TS_POS_ADAPT_LEN 8'h04
`define TS_POS_ADAPT_FLAGS 8'h05
`define TS_POS_PCR_FIRST 8'h06
`define TS_POS_PCR_LAST 8'h0B
`define ADAPT_PRESENT_BIT 5
`define PCR_FLAG_BIT 4

`define PCR_RATE_NUM 6'h1B
`define PCR_RATE_DEN 6'h28
`define PCR_EXT_MAX 9'h12B

`endif

// [src/out_fifo.v]
// Synchronous FIFO with valid/ready on both sides and a registered output.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module out_fifo #(
	parameter WIDTH = 10,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clock,
	input wire reset,
	input wire in_valid,
	input wire [WIDTH-1:0] in_data,
	output wire in_ready,
	output reg out_valid,
	output reg [WIDTH-1:0] out_data,
	input wire out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire push;
	wire pop;
	wire full;
	wire empty;

	assign full = (count == DEPTH[AW:0]);
	assign empty = (count == {(AW+1){1'b0}});
	assign in_ready = !full;
	assign push = in_valid && !full;
	// The output register refills whenever it is empty or being taken.
	assign pop = !empty && (!out_valid || out_ready);

	always @(posedge clock)
	begin
		if (reset)
		begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
			out_valid <= 1'b0;
			out_data <= {WIDTH{1'b0}};
		end
		else
		begin
			if (push)
			begin
				mem[wr_ptr] <= in_data;
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			end
			if (pop)
			begin
				out_data <= mem[rd_ptr];
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
				out_valid <= 1'b1;
			end
			else if (out_ready)
				out_valid <= 1'b0;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule // out_fifo

// [sim/ds_forward_asserts.sv]
// Port assertions for the downstream forwarding buffer, bound below.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "ds_forward_defs.vh"
module ds_forward_asserts #(
	parameter LATENCY_CYCLES = 8000
) (
	input wire clock,
	input wire reset,
	input wire [1:0] mode,
	input wire async_mode,
	input wire in_valid,
	input wire in_last,
	input wire rf_valid,
	input wire [7:0] rf_data,
	input wire rf_start,
	input wire rf_last,
	input wire rf_ready,
	input wire [15:0] drop_count,
	input wire [15:0] deleted_count,
	input wire [15:0] inserted_count,
	input wire [15:0] latency_max,
	input wire latency_violation,
	input wire skew_violation
);
// Output may only appear once a whole packet arrived or nulls may be made.
reg seen;
always @(posedge clock)
	if (reset)
		seen <= 1'b0;
	else if ((in_valid && in_last) || async_mode)
		seen <= 1'b1;
default clocking @(posedge clock); endclocking
default disable iff (reset);
chk_reset_quiet: assert property (disable iff (1'b0) reset |=>
	!rf_valid && drop_count == 16'h0000 && inserted_count == 16'h0000)
	else $error("outputs not cleared by reset");
chk_hold_output: assert property (rf_valid && !rf_ready |=> rf_valid &&
	$stable(rf_data) && $stable(rf_start) && $stable(rf_last))
	else $error("output byte changed while stalled");
chk_no_early: assert property (rf_valid |-> seen)
	else $error("output before any complete packet");
chk_drop_step: assert property ($changed(drop_count) |->
	drop_count == $past(drop_count) + 16'h0001)
	else $error("drop counter stepped wrongly");
chk_delete_async: assert property ($changed(deleted_count) |->
	$past(async_mode) && $past(mode) != `MODE_PACKET_STREAMING)
	else $error("null deleted outside asynchronous tunnel mode");
chk_insert_async: assert property ($changed(inserted_count) |->
	$past(async_mode) && $past(mode) != `MODE_PACKET_STREAMING)
	else $error("null inserted outside asynchronous tunnel mode");
chk_latency_flag: assert property (latency_violation |->
	latency_max >= LATENCY_CYCLES)
	else $error("latency flag without matching maximum");
chk_skew_flag: assert property (skew_violation |-> latency_violation)
	else $error("skew flag without latency flag");
chk_latency_mono: assert property (latency_max >= $past(latency_max))
	else $error("latency maximum decreased");
cover property (rf_valid && rf_ready && rf_last);
cover property ($changed(drop_count));
cover property ($changed(inserted_count));
endmodule // ds_forward_asserts
bind ds_forward_buffer ds_forward_asserts #(.LATENCY_CYCLES(LATENCY_CYCLES)) chk_i (
	.clock(clock), .reset(reset), .mode(mode), .async_mode(async_mode),
	.in_valid(in_valid), .in_last(in_last), .rf_valid(rf_valid), .rf_data(rf_data),
	.rf_start(rf_start), .rf_last(rf_last), .rf_ready(rf_ready),
	.drop_count(drop_count), .deleted_count(deleted_count),
	.inserted_count(inserted_count), .latency_max(latency_max),
	.latency_violation(latency_violation), .skew_violation(skew_violation));

// [sim/headend_model.sv]
// Headend source model: streams tunnel packets one byte per cycle.
// Assumes the buffer input never stalls; drives at falling edges.
`timescale 1ns/1ps
module headend_model (
	input wire clock,
	output reg in_valid,
	output reg [7:0] in_data,
	output reg in_last,
	output reg in_class_ef,
	output reg in_is_video
);
initial
begin
	in_valid = 1'b0;
	in_data = 8'h00;
	in_last = 1'b0;
	in_class_ef = 1'b0;
	in_is_video = 1'b0;
end
task automatic send(input logic [7:0] p[$], input logic ef, input logic video, input int gap);
	for (int i = 0; i < p.size(); i++)
	begin
		@(negedge clock);
		in_valid = 1'b1;
		in_data = p[i];
		in_last = (i == p.size() - 1);
		in_class_ef = ef;
		in_is_video = video;
	end
	@(negedge clock);
	in_valid = 1'b0;
	in_last = 1'b0;
	// A released data line toggles so a stale byte never looks fresh.
	in_data = ~in_data;
	repeat (gap)
	begin
		@(negedge clock);
		in_data = ~in_data;
	end
endtask
endmodule // headend_model

// [sim/tb_top.sv]
// Self-checking bench for the downstream forwarding buffer.
// Assumes the headend model drives input and this bench sinks the RF side.
`timescale 1ns/1ps
`include "ds_forward_defs.vh"
module tb_top;
reg clock = 1'b0;
reg reset = 1'b1;
reg [1:0] mode = 2'h0;
reg async_mode = 1'b0;
reg rf_ready = 1'b1;
reg in_frame = 1'b0;
wire in_valid, in_last, in_class_ef, in_is_video, rf_valid, rf_start, rf_last;
wire latency_violation, skew_violation;
wire [7:0] in_data, rf_data;
wire [15:0] drop_count, deleted_count, inserted_count, latency_max;
int fail_count = 0;
int num_checks = 0;
int k;
logic [7:0] got[$];
logic [7:0] pkt[$];
always #12.5 clock = ~clock;
headend_model core (.clock(clock), .in_valid(in_valid), .in_data(in_data),
	.in_last(in_last), .in_class_ef(in_class_ef), .in_is_video(in_is_video));
// Small queue and short limits keep the run brief.
ds_forward_buffer #(.QUEUE_AW(8), .LATENCY_CYCLES(200), .SKEW_CYCLES(400),
	.NULL_GAP_CYCLES(300)) uut (.clock(clock), .reset(reset), .mode(mode),
	.async_mode(async_mode), .in_valid(in_valid), .in_data(in_data),
	.in_last(in_last), .in_class_ef(in_class_ef), .in_is_video(in_is_video),
	.rf_valid(rf_valid), .rf_data(rf_data), .rf_start(rf_start), .rf_last(rf_last),
	.rf_ready(rf_ready), .drop_count(drop_count), .deleted_count(deleted_count),
	.inserted_count(inserted_count), .latency_max(latency_max),
	.latency_violation(latency_violation), .skew_violation(skew_violation));
task chk(input logic [15:0] a, input logic [15:0] e, input string m);
	num_checks++;
	if (a !== e)
	begin
		fail_count++;
		$display("[FAIL] %0t %s got %h exp %h", $time, m, a, e);
	end
endtask
task chk_seg(input int off, input bit skip_pcr);
	for (int i = 0; i < pkt.size(); i++)
		if (!skip_pcr || i < 6 || i > 11)
			chk({8'h00, got[off + i]}, {8'h00, pkt[i]}, "byte");
endtask
function void mk(input int n, input logic [7:0] b);
	pkt.delete();
	for (int i = 0; i < n; i++)
		pkt.push_back(b + i[7:0]);
endfunction
function void mk_ts(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] ctl);
	mk(188, 8'h00);
	pkt[0] = `TS_SYNC;
	pkt[1] = hi;
	pkt[2] = lo;
	pkt[3] = ctl;
	pkt[4] = 8'h07;
	pkt[5] = 8'h10;
endfunction
task wait_bytes(input int n);
	int t;
	t = 0;
	while (got.size() < n && t < 3000)
	begin
		@(negedge clock);
		t++;
	end
	chk(got.size() >= n, 16'h0001, "byte count");
endtask
task tally_and_finish;
	if (fail_count == 0 && num_checks > 0)
		$display("Simulation passed");
	else
		$display("Simulation failed");
	$finish;
endtask
always @(posedge clock)
	if (!reset && rf_valid && rf_ready)
	begin
		got.push_back(rf_data);
		chk(rf_start, !in_frame, "start mark");
		in_frame <= !rf_last;
	end
initial
begin
	repeat (10000) @(posedge clock);
	fail_count++;
	tally_and_finish;
end
initial
begin
	repeat (8) @(negedge clock);
	reset = 1'b0;
	@(negedge clock);
	chk(drop_count, 16'h0000, "drop reset");
	chk(inserted_count, 16'h0000, "insert reset");
	mk(12, 8'h20);
	core.send(pkt, 1'b0, 1'b0, 40);
	wait_bytes(12);
	chk_seg(0, 0);
	chk(latency_max != 16'h0000, 16'h0001, "latency seen");
	got.delete();
	rf_ready = 1'b0;
	mk(20, 8'h10);
	core.send(pkt, 1'b0, 1'b0, 0);
	mk(6, 8'h40);
	core.send(pkt, 1'b0, 1'b0, 0);
	mk(6, 8'h80);
	core.send(pkt, 1'b1, 1'b0, 0);
	rf_ready = 1'b1;
	wait_bytes(32);
	mk(20, 8'h10);
	chk_seg(0, 0);
	mk(6, 8'h80);
	chk_seg(20, 0);
	mk(6, 8'h40);
	chk_seg(26, 0);
	got.delete();
	rf_ready = 1'b0;
	mk(100, 8'h00);
	repeat (3) core.send(pkt, 1'b0, 1'b0, 0);
	repeat (4) @(negedge clock);
	chk(drop_count, 16'h0001, "drop");
	rf_ready = 1'b1;
	wait_bytes(200);
	repeat (50) @(negedge clock);
	chk(got.size(), 16'd200, "kept bytes");
	got.delete();
	mode = `MODE_TRANSPORT_TUNNEL;
	mk_ts(`NULL_PID_HI, `NULL_PID_LO, `NULL_ADAPT);
	core.send(pkt, 1'b0, 1'b1, 40);
	mk_ts(8'h01, 8'h00, 8'h30);
	core.send(pkt, 1'b0, 1'b1, 40);
	wait_bytes(376);
	chk_seg(188, 0);
	mk_ts(`NULL_PID_HI, `NULL_PID_LO, `NULL_ADAPT);
	chk_seg(0, 0);
	got.delete();
	mode = `MODE_MULTICHANNEL_MPEG;
	async_mode = 1'b1;
	core.send(pkt, 1'b0, 1'b1, 40);
	mk_ts(8'h01, 8'h00, 8'h30);
	core.send(pkt, 1'b0, 1'b1, 40);
	repeat (800) @(negedge clock);
	chk(deleted_count, 16'h0001, "null deleted");
	chk(inserted_count != 16'h0000, 16'h0001, "null inserted");
	k = 0;
	while (k + 188 < got.size() && got[k + 1] === `NULL_PID_HI)
		k += 188;
	chk_seg(k, 1);
	chk({8'h00, got[k + 10] & 8'h7E}, 16'h007E, "pcr reserved");
	k = (k == 0) ? 188 : 0;
	chk({got[k + 1], got[k + 2]}, 16'h1FFF, "null pid");
	async_mode = 1'b0;
	mode = `MODE_PACKET_STREAMING;
	chk(latency_violation, 16'h0000, "latency flag");
	chk(skew_violation, 16'h0000, "skew flag");
	tally_and_finish;
end
endmodule // tb_top
